//--- design/tacq_pkg.sv
// Purpose: Shared constants and types for the interrupt request block
// Assumes: 8-bit register port, one system clock
// Notes: Offsets are the printed register addresses
package tacq_pkg;
    localparam logic [7:0] ADDR_CMP_A_MODE = 8'h9c;
    localparam logic [7:0] ADDR_CMP_B_MODE = 8'h9d;
    localparam logic [7:0] ADDR_CMP_C_MODE = 8'h9e;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'hc8;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hc9;
    localparam logic [7:0] ADDR_STACK_CTRL = 8'hdf;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'he0;
    localparam int BIT_EXT = 0;
    localparam int BIT_CMP0 = 1;
    localparam int BIT_TMR0 = 4;
    localparam int BIT_TCNT = 5;
    localparam int BIT_ADC = 7;
    localparam int MODE_EN = 7;
    localparam int MODE_EDGE = 3;
    localparam int GIE_BIT = 7;
    localparam int NUM_CMP = 3;
    localparam logic [7:0] FLAG_RST = 8'h40;
    localparam logic [7:0] FLAG_MASK = 8'hbf;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CMP_A_MODE_MASK = 8'hf8;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [2:0] STACK_RST = 3'h7;
    localparam logic [15:0] VECTOR_ADDR = 16'h0008;

    typedef struct packed {
        logic tmr0_ovf;
        logic tcnt_ovf;
        logic adc_done;
        logic ext_evt;
    } tacq_evt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tacq_bus_t;
endpackage

//--- design/tacq_edge_det.sv
// Purpose: Synchronise one comparator output and detect selected edge
// Assumes: Comparator output asynchronous to the system clock
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module tacq_edge_det (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cmp_out,
    input wire logic i_enable,
    input wire logic i_edge_sel,
    output logic o_hit
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= i_cmp_out;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Disabled comparator never reports an edge
    always_comb begin
        o_hit = 1'b0;
        if (i_enable) begin
            if (i_edge_sel) begin
                o_hit = sync_r & ~prev_r;
            end else begin
                o_hit = ~sync_r & prev_r;
            end
        end
    end
endmodule

//--- design/tacq_irq_ctrl.sv
// Purpose: Interrupt request flags, enables and vector request logic
// Assumes: Overflow and conversion events are one-cycle pulses
// Notes: Flag bits are set by hardware and cleared by writing a one
//
// Overview of operation
// - Basic timer overflow always sets its flag
// - Enabled timer flag requests the vector
// - Disabled timer still flags, no vector
// - Timer/counter overflow always sets its flag
// - Enabled timer/counter flag requests vector
// - Disabled timer/counter flags without vector
// - Conversion end always sets its flag
// - Enabled conversion flag requests vector
// - Disabled conversion flags without vector
// - Three comparators, each with edge select
// - Selected comparator edge sets its flag
// - Disabled comparator never sets its flag
// - Enabled comparator edge enters vector eight
// - Edge bit: zero falling, one rising
// - Flags stay set until software clears
// - Global enable gates vector; pushes stack
// - All flags in one register, fixed bits
// - Enables share flag bit layout, reset zero
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module tacq_irq_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_tmr0_ovf,
    input wire logic i_tcnt_ovf,
    input wire logic i_adc_done,
    input wire logic i_ext_evt,
    input wire logic [2:0] i_cmp_out,
    input wire logic i_vec_ack,
    output logic [7:0] o_rdata,
    output logic o_vec_req,
    output logic [15:0] o_vec_addr,
    output logic o_stack_push,
    output logic o_irq
);
    tacq_pkg::tacq_evt_t evt;
    tacq_pkg::tacq_bus_t bus;
    logic [7:0] flag_r;
    logic [7:0] flag_nxt;
    logic [7:0] enable_r;
    logic [7:0] mask_r;
    logic [7:0] mode_r [tacq_pkg::NUM_CMP];
    logic [2:0] stack_r;
    logic gie_r;
    logic [7:0] set_vec;
    logic [2:0] cmp_hit;
    logic pending;
    logic take;
    logic flag_wr;

    assign evt = '{tmr0_ovf: i_tmr0_ovf, tcnt_ovf: i_tcnt_ovf,
                   adc_done: i_adc_done, ext_evt: i_ext_evt};
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // One edge detector per comparator
    genvar g;
    generate
        for (g = 0; g < tacq_pkg::NUM_CMP; g++) begin : g_cmp
            tacq_edge_det u_edge (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .i_cmp_out(i_cmp_out[g]),
                .i_enable(mode_r[g][tacq_pkg::MODE_EN]),
                .i_edge_sel(mode_r[g][tacq_pkg::MODE_EDGE]),
                .o_hit(cmp_hit[g])
            );
        end
    endgenerate

    // Event sources land on their own flag bits
    always_comb begin
        set_vec = 8'h00;
        set_vec[tacq_pkg::BIT_EXT] = evt.ext_evt;
        set_vec[tacq_pkg::BIT_CMP0 +: 3] = cmp_hit;
        set_vec[tacq_pkg::BIT_TMR0] = evt.tmr0_ovf;
        set_vec[tacq_pkg::BIT_TCNT] = evt.tcnt_ovf;
        set_vec[tacq_pkg::BIT_ADC] = evt.adc_done;
    end

    assign flag_wr = bus.wr && (bus.addr == tacq_pkg::ADDR_IRQ_FLAG);

    // Set wins over clear so an event in the clear cycle survives
    always_comb begin
        flag_nxt = flag_r;
        if (flag_wr) begin
            flag_nxt = flag_r & ~bus.wdata;
        end
        flag_nxt = (flag_nxt | set_vec) & tacq_pkg::FLAG_MASK;
        flag_nxt = flag_nxt | tacq_pkg::FLAG_RST;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            flag_r <= tacq_pkg::FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            enable_r <= tacq_pkg::ENABLE_RST;
            mask_r <= tacq_pkg::MASK_RST;
        end else if (bus.wr) begin
            if (bus.addr == tacq_pkg::ADDR_IRQ_ENABLE) begin
                enable_r <= bus.wdata & tacq_pkg::FLAG_MASK;
            end else if (bus.addr == tacq_pkg::ADDR_IRQ_MASK) begin
                mask_r <= bus.wdata & tacq_pkg::FLAG_MASK;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < tacq_pkg::NUM_CMP; i++) begin
                mode_r[i] <= tacq_pkg::MODE_RST;
            end
        end else if (bus.wr) begin
            if (bus.addr == tacq_pkg::ADDR_CMP_A_MODE) begin
                mode_r[0] <= bus.wdata & tacq_pkg::CMP_A_MODE_MASK;
            end else if (bus.addr == tacq_pkg::ADDR_CMP_B_MODE) begin
                mode_r[1] <= bus.wdata;
            end else if (bus.addr == tacq_pkg::ADDR_CMP_C_MODE) begin
                mode_r[2] <= bus.wdata;
            end
        end
    end

    // Vector taken only when a flag meets its enable under global enable;
    // disabled sources keep flagging but never reach the vector
    assign pending =
        |(flag_r & enable_r & tacq_pkg::FLAG_MASK);
    assign take = gie_r && pending && !o_vec_req;

    // Entering the vector clears the global enable, as a CPU does,
    // so one request is not taken twice before the handler runs.
    // Entry wins a same-cycle write, so push and pointer always agree
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            gie_r <= 1'b0;
            stack_r <= tacq_pkg::STACK_RST;
        end else if (take) begin
            gie_r <= 1'b0;
            stack_r <= stack_r - 3'h1;
        end else if (bus.wr && bus.addr == tacq_pkg::ADDR_STACK_CTRL) begin
            gie_r <= bus.wdata[tacq_pkg::GIE_BIT];
            stack_r <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_vec_req <= 1'b0;
            o_vec_addr <= 16'h0000;
            o_stack_push <= 1'b0;
        end else begin
            o_stack_push <= take;
            if (take) begin
                o_vec_req <= 1'b1;
                o_vec_addr <= tacq_pkg::VECTOR_ADDR;
            end else if (i_vec_ack) begin
                o_vec_req <= 1'b0;
            end
        end
    end

    // Level output follows the mask register, apart from the vector gate
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flag_nxt & mask_r & tacq_pkg::FLAG_MASK);
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (!bus.rd) begin
            o_rdata <= 8'h00;
        end else if (bus.addr == tacq_pkg::ADDR_IRQ_FLAG) begin
            o_rdata <= flag_r;
        end else if (bus.addr == tacq_pkg::ADDR_IRQ_ENABLE) begin
            o_rdata <= enable_r;
        end else if (bus.addr == tacq_pkg::ADDR_IRQ_MASK) begin
            o_rdata <= mask_r;
        end else if (bus.addr == tacq_pkg::ADDR_STACK_CTRL) begin
            o_rdata <= {gie_r, 4'h0, stack_r};
        end else if (bus.addr == tacq_pkg::ADDR_CMP_A_MODE) begin
            o_rdata <= mode_r[0];
        end else if (bus.addr == tacq_pkg::ADDR_CMP_B_MODE) begin
            o_rdata <= mode_r[1];
        end else if (bus.addr == tacq_pkg::ADDR_CMP_C_MODE) begin
            o_rdata <= mode_r[2];
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Flag setting, vector gating, stack and read-back checks
    tmr0_flag_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_tmr0_ovf |=> flag_r[tacq_pkg::BIT_TMR0])
        else $error("timer overflow did not set flag");

    tcnt_flag_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_tcnt_ovf |=> flag_r[tacq_pkg::BIT_TCNT])
        else $error("timer/counter overflow did not set flag");

    adc_flag_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_adc_done |=> flag_r[tacq_pkg::BIT_ADC])
        else $error("conversion end did not set flag");

    cmp_flag_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cmp_hit != 3'h0) |=>
        (flag_r[tacq_pkg::BIT_CMP0 +: 3] & $past(cmp_hit)) == $past(cmp_hit))
        else $error("comparator edge did not set flag");

    cmp_off_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!mode_r[0][tacq_pkg::MODE_EN] && !flag_r[1] && !flag_wr) |=>
        !flag_r[1])
        else $error("disabled comparator set flag");

    tmr0_vec_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (gie_r && !o_vec_req && flag_r[tacq_pkg::BIT_TMR0] &&
        enable_r[tacq_pkg::BIT_TMR0]) |=> o_vec_req)
        else $error("enabled timer flag did not enter vector");

    tcnt_vec_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (gie_r && !o_vec_req && flag_r[tacq_pkg::BIT_TCNT] &&
        enable_r[tacq_pkg::BIT_TCNT]) |=> o_vec_req)
        else $error("enabled timer/counter flag did not enter vector");

    adc_vec_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (gie_r && !o_vec_req && flag_r[tacq_pkg::BIT_ADC] &&
        enable_r[tacq_pkg::BIT_ADC]) |=> o_vec_req)
        else $error("enabled conversion flag did not enter vector");

    cmp_vec_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (gie_r && !o_vec_req && |(flag_r[tacq_pkg::BIT_CMP0 +: 3] &
        enable_r[tacq_pkg::BIT_CMP0 +: 3])) |=>
        o_vec_req && o_vec_addr == tacq_pkg::VECTOR_ADDR)
        else $error("enabled comparator flag did not enter vector");

    quiet_vec_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!o_vec_req && (flag_r & enable_r & tacq_pkg::FLAG_MASK) == 8'h00)
        |=> !o_vec_req && !o_stack_push)
        else $error("vector entered without an enabled flag");

    no_vec_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(o_vec_req) |-> $past(gie_r) && $past(pending))
        else $error("vector requested without enable");

    gie_gate_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!gie_r && !o_vec_req) |=> !o_vec_req && !o_stack_push)
        else $error("vector entered with global enable off");

    vec_take_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (gie_r && pending && !o_vec_req && !i_vec_ack) |=>
        o_vec_req && o_stack_push && o_vec_addr == tacq_pkg::VECTOR_ADDR)
        else $error("enabled request did not enter vector");

    stack_push_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        take |=> o_stack_push && !gie_r &&
        stack_r == $past(stack_r) - 3'h1)
        else $error("vector entry did not push the stack");

    push_once_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_stack_push |=> !o_stack_push)
        else $error("one entry pushed the stack twice");

    vec_hold_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_vec_req && !i_vec_ack) |=>
        o_vec_req && o_vec_addr == tacq_pkg::VECTOR_ADDR)
        else $error("vector request dropped before acknowledge");

    vec_ack_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_vec_req && i_vec_ack) |=> !o_vec_req)
        else $error("vector request stood after acknowledge");

    flag_hold_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (flag_r[tacq_pkg::BIT_TMR0] && !flag_wr) |=>
        flag_r[tacq_pkg::BIT_TMR0])
        else $error("flag dropped without clear");

    flag_clear_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (flag_wr && bus.wdata[tacq_pkg::BIT_TMR0] &&
        !set_vec[tacq_pkg::BIT_TMR0]) |=> !flag_r[tacq_pkg::BIT_TMR0])
        else $error("written one did not clear flag");

    set_wins_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (flag_wr && set_vec != 8'h00) |=>
        (flag_r & $past(set_vec)) == $past(set_vec))
        else $error("clear in the event cycle lost the flag");

    flag_read_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.rd && bus.addr == tacq_pkg::ADDR_IRQ_FLAG) |=>
        o_rdata == $past(flag_r))
        else $error("flag register read back wrong");

    en_read_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (bus.rd && bus.addr == tacq_pkg::ADDR_IRQ_ENABLE) |=>
        o_rdata == $past(enable_r))
        else $error("enable register read back wrong");

    irq_level_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !(bus.wr && bus.addr == tacq_pkg::ADDR_IRQ_MASK) |=>
        o_irq == |(flag_r & mask_r & tacq_pkg::FLAG_MASK))
        else $error("interrupt output does not follow flags");

    flag_reset_a: assert property (
        @(posedge i_ref_clk)
        !i_rst_n |=> flag_r == tacq_pkg::FLAG_RST)
        else $error("flag register not at reset value");

    en_reset_a: assert property (
        @(posedge i_ref_clk)
        !i_rst_n |=> enable_r == tacq_pkg::ENABLE_RST)
        else $error("enable register not cleared by reset");

    out_reset_a: assert property (
        @(posedge i_ref_clk)
        !i_rst_n |=> !o_vec_req && !o_stack_push && !o_irq)
        else $error("outputs not idle after reset");
endmodule

//--- dv/tacq_cpu_model.sv
// Purpose: CPU sequencer stand-in that takes the interrupt vector
// Assumes: Vector request is a level held until acknowledged
// Notes: Slow mode waits four extra cycles before acknowledging
`timescale 1ns/10ps
module tacq_cpu_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_vec_req,
    input wire logic i_slow,
    output logic o_vec_ack
);
    logic [2:0] wait_r;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wait_r <= 3'h0;
            o_vec_ack <= 1'b0;
        end else begin
            o_vec_ack <= 1'b0;
            // One pulse per entry, a second would hide a lost request
            if (i_vec_req && !o_vec_ack) begin
                if (wait_r >= (i_slow ? 3'h4 : 3'h0)) begin
                    o_vec_ack <= 1'b1;
                    wait_r <= 3'h0;
                end else begin
                    wait_r <= wait_r + 3'h1;
                end
            end
        end
    end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the interrupt request block
// Assumes: CPU model acknowledges every vector request
// Notes: Stack level and global enable are tracked here and checked against read-back
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
    logic gie_x = 1'b0, ack, vec_req, push, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, d, en_x, rdata;
    logic [3:0] ev = 4'h0;
    logic [2:0] cmp = 3'h0, sp = 3'h7;
    logic [31:0] seed = 32'h3de5;
    logic [15:0] vec_addr;
    logic [7:0] bitpos [4] = '{8'h10, 8'h20, 8'h80, 8'h01};
    logic [7:0] ra [7] = '{8'hc8, 8'hc9, 8'h9c, 8'h9d, 8'h9e, 8'hdf, 8'he0};
    logic [7:0] rv [7] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
    int n_mismatch = 0, total_checks = 0, n_push = 0, p0 = 0;

    tacq_irq_ctrl tacq_irq_ctrl_i (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_tmr0_ovf(ev[0]), .i_tcnt_ovf(ev[1]),
        .i_adc_done(ev[2]), .i_ext_evt(ev[3]), .i_cmp_out(cmp),
        .i_vec_ack(ack), .o_rdata(rdata), .o_vec_req(vec_req),
        .o_vec_addr(vec_addr), .o_stack_push(push), .o_irq(irq));
    tacq_cpu_model tacq_cpu_model_i (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_vec_req(vec_req), .i_slow(slow), .o_vec_ack(ack));

    always #20 clk = ~clk;
    always @(posedge clk) if (push === 1'b1) n_push++;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic set_gie(input logic g);
        gie_x = g;
        wr_reg(tacq_pkg::ADDR_STACK_CTRL, {g, 4'h0, sp});
    endtask

    // Clears old flags first, so only the coming event can set one
    task automatic arm(input logic [7:0] en, input logic g);
        en_x = en;
        wr_reg(tacq_pkg::ADDR_IRQ_FLAG, 8'hff);
        wr_reg(tacq_pkg::ADDR_IRQ_ENABLE, en);
        wr_reg(tacq_pkg::ADDR_IRQ_MASK, en);
        set_gie(g);
        p0 = n_push;
        seed = lfsr(seed);
        slow <= seed[0];
    endtask

    // Twelve cycles cover sync, request and a slow acknowledge
    task automatic verdict(input logic [7:0] fl, input logic took);
        repeat (12) @(posedge clk);
        #1;
        check(16'(n_push - p0), took);
        check(irq, |(fl & en_x));
        check(vec_req, 16'h0);
        if (took) begin
            sp = sp - 3'h1;
            gie_x = 1'b0;
            check(vec_addr, tacq_pkg::VECTOR_ADDR);
        end
        rd_reg(tacq_pkg::ADDR_IRQ_FLAG);
        check(d, fl | tacq_pkg::FLAG_RST);
        rd_reg(tacq_pkg::ADDR_STACK_CTRL);
        check(d, {gie_x, 4'h0, sp});
    endtask

    // Reset, at start and again after all tests, must restore every default
    task automatic reset_check();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        sp = 3'h7;
        gie_x = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd_reg(ra[i]);
            check(d, rv[i]);
        end
        check(vec_addr, 16'h0000);
        check(irq, 1'b0);
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        reset_check();
        for (int c = 0; c < 3; c++) begin
            seed = lfsr(seed);
            wr_reg(tacq_pkg::ADDR_CMP_A_MODE + 8'(c), seed[7:0]);
            rd_reg(tacq_pkg::ADDR_CMP_A_MODE + 8'(c));
            check(d, seed[7:0] & (c == 0 ? 8'hf8 : 8'hff));
        end
        wr_reg(tacq_pkg::ADDR_IRQ_ENABLE, seed[15:8]);
        rd_reg(tacq_pkg::ADDR_IRQ_ENABLE);
        check(d, seed[15:8] & tacq_pkg::FLAG_MASK);
        wr_reg({1'b0, seed[6:0]}, seed[23:16]);
        rd_reg({1'b0, seed[6:0]});
        check(d, 8'h00);
        for (int k = 0; k < 4; k++)
            for (int en = 0; en < 2; en++) begin
                arm(en[0] ? bitpos[k] : 8'h00, 1'b1);
                pulse(k);
                verdict(bitpos[k], en[0]);
            end
        // Pending flag waits for the global enable, then enters
        arm(8'h10, 1'b0);
        pulse(0);
        verdict(8'h10, 1'b0);
        p0 = n_push;
        set_gie(1'b1);
        verdict(8'h10, 1'b1);
        for (int c = 0; c < 3; c++)
            for (int s = 0; s < 2; s++) begin
                wr_reg(tacq_pkg::ADDR_CMP_A_MODE + 8'(c), {4'h8, s[0], 3'h0});
                cmp[c] <= ~s[0];
                repeat (4) @(posedge clk);
                arm(8'h02 << c, 1'b1);
                cmp[c] <= s[0];
                verdict(8'h02 << c, 1'b1);
                arm(8'h02 << c, 1'b1);
                cmp[c] <= ~s[0];
                verdict(8'h00, 1'b0);
                wr_reg(tacq_pkg::ADDR_CMP_A_MODE + 8'(c), {4'h0, s[0], 3'h0});
                arm(8'h02 << c, 1'b1);
                cmp[c] <= s[0];
                verdict(8'h00, 1'b0);
            end
        reset_check();
        print_verdict();
    end

    // Tests need about 800 cycles; over seven times that means a hang
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
